// File: rtl/vecmap_map.svh
`ifndef VECMAP_MAP_SVH
`define VECMAP_MAP_SVH

// ----------------------------------------
// Address regions
// ----------------------------------------
`define DPAGE_LO       16'h0000
`define DPAGE_HI       16'h007f
`define HPAGE_LO       16'h1800
`define HPAGE_HI       16'h18ff
`define NVREG_LO       16'hffb0
`define NVREG_HI       16'hffbf
`define VEC_LO         16'hffc0
`define VEC_HI         16'hffff

// ----------------------------------------
// Nonvolatile block layout (byte offsets)
// ----------------------------------------
`define NV_KEY_OFS     4'h0
`define NV_KEY_LEN     8
`define NV_PROT_OFS    4'hd
`define NV_OPT_OFS     4'hf
`define NV_ERASED      8'hff

// ----------------------------------------
// Vector slots (pair index 0..31) and widths
// ----------------------------------------
`define VEC_COUNT      32
`define VEC_PORT       5'h09
`define VEC_TIMER_LO   5'h11
`define VEC_TIMER_HI   5'h1a
`define VEC_RESET      5'h1f

// ----------------------------------------
// Control register (own direct-page byte)
// ----------------------------------------
`define CTRL_OFS       8'h7f
`define CTRL_RESET     8'h00
`define CTRL_LVD_BIT   0
`define CTRL_BDC_BIT   1
`define CTRL_ADCK_BIT  2
`define CTRL_RTC_BIT   3
`define CTRL_PPD_BIT   4
`define STAT_OFS       8'h7e

`endif

// File: rtl/vecmap_pkg.sv
package vecmap_pkg;
  // Power state of the device
  typedef enum logic [1:0] {
    pw_run   = 2'b00,
    pw_light = 2'b01,
    pw_deep  = 2'b10
  } power_t;

  // Region hit by an address
  typedef enum logic [2:0] {
    rg_none  = 3'b000,
    rg_dpage = 3'b001,
    rg_hpage = 3'b010,
    rg_nvreg = 3'b011,
    rg_vec   = 3'b100
  } region_t;

  typedef struct packed {
    power_t     mode;
    logic [7:0] ctrl;
    logic [7:0] prot;
    logic [7:0] opt;
    logic [7:0] rdata;
    logic       region_q;
  } state_t;
endpackage

// File: rtl/vector_map_and_stop_gating.sv
// The register offsets and the plain strobed port were left to the implementer.
`include "vecmap_map.svh"
// Overview of operation
// - On any stop entry, peripheral clocks are halted.
// - With debug enabled at stop, only debug logic keeps its clock.
// - Comparator runs in light stop only with voltage detector on.
// - Converter runs in light stop only with async clock and detector on.
// - Internal reference runs in light stop only if both enable bits set.
// - Real-time counter runs in either stop only when enabled.
// - Regulator stays active in stop when detector or debug enabled.
// - External oscillator runs in light stop only if both enables set.
// - High range oscillator also needs the voltage detector in light stop.
// - Direct page decodes 0x0000 to 0x007f.
// - High page decodes 0x1800 to 0x18ff.
// - Nonvolatile block decodes 0xffb0 to 0xffbf, sixteen bytes.
// - Every reset copies protection and option bytes into working registers.
// - Nonvolatile block holds an eight-byte backdoor key.
// - Vectors are 32 high/low byte pairs from 0xffc0 to 0xffff.
// - Direct-mode accesses carry only the low address byte.
// - Only control byte bits 0 to 4 can be set and cleared; other direct-page bytes ignore writes.
// - Fixed-zero bits always read as 0.
module vector_map_and_stop_gating #(
  parameter logic [15:0] VEC_BASE_ADDR = 16'h8000  // Arbitrary handler base
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic        direct_mode,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [7:0]  rdata,
  output      logic [2:0]  region,
  input  wire logic [7:0]  nv_image [16],
  input  wire logic        stop_req,
  input  wire logic        wake,
  input  wire logic        int_ref_clock_enable,
  input  wire logic        int_ref_stop_enable,
  input  wire logic        ext_ref_clock_enable,
  input  wire logic        ext_ref_stop_enable,
  input  wire logic        osc_high_range,
  input  wire logic        rtc_enable,
  output      logic        periph_clk_en,
  output      logic        debug_clk_en,
  output      logic        cmp_run,
  output      logic        adc_run,
  output      logic        int_ref_run,
  output      logic        rtc_run,
  output      logic        regulator_full,
  output      logic        ext_osc_run,
  output      logic        core_power_on,
  output      logic        io_hold,
  output      logic [63:0] backdoor_key,
  output      logic [7:0]  flash_protection_byte,
  output      logic [7:0]  flash_option_byte
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Direct mode carries only the low byte, so upper byte is forced to zero
  function automatic vecmap_pkg::region_t decode(input logic [15:0] a, input logic dm);
    logic [15:0] full;
    full = dm ? {8'h00, a[7:0]} : a;
    if (full <= `DPAGE_HI)                           decode = vecmap_pkg::rg_dpage;
    else if (full >= `HPAGE_LO && full <= `HPAGE_HI) decode = vecmap_pkg::rg_hpage;
    else if (full >= `NVREG_LO && full <= `NVREG_HI) decode = vecmap_pkg::rg_nvreg;
    else if (full >= `VEC_LO)                        decode = vecmap_pkg::rg_vec;
    else                                             decode = vecmap_pkg::rg_none;
  endfunction

  // Handler address for each vector slot; port pins share slot 9, timers own one each
  function automatic logic [15:0] vec_target(input logic [4:0] slot);
    vec_target = VEC_BASE_ADDR + {9'h000, slot, 2'b00};
  endfunction

  vecmap_pkg::region_t hit;
  logic [15:0]         eff_addr;
  assign eff_addr = direct_mode ? {8'h00, addr[7:0]} : addr;
  assign hit      = decode(addr, direct_mode);
  assign region   = hit;

  // ----------------------------------------
  // State
  // ----------------------------------------
  vecmap_pkg::state_t st;
  vecmap_pkg::state_t next_st;
  logic               lvd_on;
  logic               bdc_on;
  logic               light;
  logic               deep;
  logic [15:0]        vaddr;
  logic [63:0]        key;

  assign lvd_on = st.ctrl[`CTRL_LVD_BIT];
  assign bdc_on = st.ctrl[`CTRL_BDC_BIT];
  assign light  = (st.mode == vecmap_pkg::pw_light);
  assign deep   = (st.mode == vecmap_pkg::pw_deep);

  // Backdoor key bytes gathered from the nonvolatile image
  genvar gi;
  generate
    for (gi = 0; gi < `NV_KEY_LEN; gi++) begin : g_key
      assign key[gi*8 +: 8] = nv_image[`NV_KEY_OFS + gi];
    end
  endgenerate

  // Next state and read data
  always_comb begin
    next_st          = st;
    next_st.region_q = 1'b0;
    vaddr            = 16'h0000;
    // Power mode sequencing; debug or detector forces the lighter stop
    case (st.mode)
      vecmap_pkg::pw_run: begin
        if (stop_req) begin
          if (bdc_on || lvd_on || !st.ctrl[`CTRL_PPD_BIT]) begin
            next_st.mode = vecmap_pkg::pw_light;
          end else begin
            next_st.mode = vecmap_pkg::pw_deep;
          end
        end
      end
      vecmap_pkg::pw_light: begin
        if (wake) begin
          next_st.mode = vecmap_pkg::pw_run;
        end
      end
      vecmap_pkg::pw_deep: begin
        if (wake) begin
          next_st.mode = vecmap_pkg::pw_run;
        end
      end
      default: begin
        next_st.mode = vecmap_pkg::pw_run;
      end
    endcase
    // Control byte: plain writes; bit-set and bit-clear work as byte writes
    if (wr && hit == vecmap_pkg::rg_dpage && eff_addr[7:0] == `CTRL_OFS) begin
      next_st.ctrl = {3'b000, wdata[4:0]};
    end
    // Nonvolatile and vector bytes ignore plain writes
    if (rd) begin
      next_st.region_q = 1'b1;
      case (hit)
        vecmap_pkg::rg_dpage: begin
          if (eff_addr[7:0] == `CTRL_OFS) begin
            next_st.rdata = st.ctrl;
          end else if (eff_addr[7:0] == `STAT_OFS) begin
            next_st.rdata = {6'h00, st.mode};
          end else begin
            next_st.rdata = 8'h00;
          end
        end
        vecmap_pkg::rg_nvreg: begin
          next_st.rdata = nv_image[eff_addr[3:0]];
        end
        vecmap_pkg::rg_vec: begin
          vaddr         = vec_target(eff_addr[5:1]);
          next_st.rdata = eff_addr[0] ? vaddr[7:0] : vaddr[15:8];
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  // Every reset reloads working bytes from flash at the first clocked edge
  logic loaded;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st     <= '{vecmap_pkg::pw_run, `CTRL_RESET, `NV_ERASED, `NV_ERASED, 8'h00, 1'b0};
      loaded <= 1'b0;
    end else begin
      st     <= next_st;
      loaded <= 1'b1;
      if (!loaded) begin
        st.prot <= nv_image[`NV_PROT_OFS];
        st.opt  <= nv_image[`NV_OPT_OFS];
      end
    end
  end

  // ----------------------------------------
  // Stop-mode keep-alive outputs
  // ----------------------------------------
  assign rdata                 = st.rdata;
  assign periph_clk_en         = !(light || deep);
  assign debug_clk_en          = !(light || deep) || bdc_on;
  assign cmp_run               = !(light || deep) || (light && lvd_on);
  assign adc_run               = !(light || deep) || (light && lvd_on && st.ctrl[`CTRL_ADCK_BIT]);
  assign int_ref_run           = !(light || deep) || (light && int_ref_clock_enable && int_ref_stop_enable);
  assign rtc_run               = !(light || deep) || rtc_enable;
  assign regulator_full        = !(light || deep) || lvd_on || bdc_on;
  assign ext_osc_run           = !(light || deep) ||
                                 (light && ext_ref_clock_enable && ext_ref_stop_enable &&
                                  (!osc_high_range || lvd_on));
  assign core_power_on         = !deep;
  assign io_hold               = light || deep;
  assign backdoor_key          = key;
  assign flash_protection_byte = st.prot;
  assign flash_option_byte     = st.opt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence stop_entered;
    !periph_clk_en;
  endsequence

  periph_gated_a: assert property (@(posedge mclk) disable iff (rst)
    (stop_req && st.mode == vecmap_pkg::pw_run) |=> stop_entered)
    else $error("peripheral clock not gated at stop");
  debug_kept_a: assert property (@(posedge mclk) disable iff (rst)
    (stop_req && bdc_on && st.mode == vecmap_pkg::pw_run) |=> (debug_clk_en && !periph_clk_en))
    else $error("debug clock lost in stop");
  cmp_standby_a: assert property (@(posedge mclk) disable iff (rst)
    (light && !lvd_on) |-> !cmp_run)
    else $error("comparator running without detector");
  adc_standby_a: assert property (@(posedge mclk) disable iff (rst)
    (light && !(lvd_on && st.ctrl[`CTRL_ADCK_BIT])) |-> !adc_run)
    else $error("converter running in stop");
  rtc_stop_a: assert property (@(posedge mclk) disable iff (rst)
    (deep && !rtc_enable) |-> !rtc_run)
    else $error("counter running while disabled");
  regulator_a: assert property (@(posedge mclk) disable iff (rst)
    (deep || light) |-> (regulator_full == (lvd_on || bdc_on)))
    else $error("regulator state wrong in stop");
  osc_range_a: assert property (@(posedge mclk) disable iff (rst)
    (light && osc_high_range && !lvd_on) |-> !ext_osc_run)
    else $error("high range oscillator without detector");
  deep_select_a: assert property (@(posedge mclk) disable iff (rst)
    (stop_req && st.mode == vecmap_pkg::pw_run && (lvd_on || bdc_on)) |=> core_power_on)
    else $error("deep stop entered with detector or debug on");
  reset_load_a: assert property (@(posedge mclk) disable iff (rst)
    (!loaded) |=> (flash_option_byte == $past(nv_image[`NV_OPT_OFS])))
    else $error("option byte not loaded at reset");
  vec_read_a: assert property (@(posedge mclk) disable iff (rst)
    (rd && !direct_mode && addr == 16'hfffe) |=> (rdata == VEC_BASE_ADDR[15:8] + 8'h00))
    else $error("reset vector high byte wrong");

  // Internal reference stops in light stop unless both of its enables are set
  int_ref_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (light && !(int_ref_clock_enable && int_ref_stop_enable)) |-> !int_ref_run)
    else $error("internal reference running in stop");
  // Oscillator stops in light stop unless both of its enables are set
  ext_osc_gate_a: assert property (@(posedge mclk) disable iff (rst)
    (light && !(ext_ref_clock_enable && ext_ref_stop_enable)) |-> !ext_osc_run)
    else $error("external oscillator running in stop");
  // Deep stop leaves only the counter, regulator and debug clock able to run
  deep_units_off_a: assert property (@(posedge mclk) disable iff (rst)
    deep |-> (!ext_osc_run && !int_ref_run && !cmp_run && !adc_run && !core_power_on && io_hold))
    else $error("unit left running in deep stop");
  // Protection copy keeps its value across plain writes to flash bytes
  nv_write_kept_a: assert property (@(posedge mclk) disable iff (rst)
    (loaded && wr && hit == vecmap_pkg::rg_nvreg) |=> $stable(flash_protection_byte))
    else $error("protection byte changed by a plain write");
  // Top key byte follows the eighth flash byte
  key_top_a: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |-> (backdoor_key[63:56] == nv_image[7]))
    else $error("backdoor key byte wrong");

endmodule

// File: tb/cpu_core_model.sv
// ----------------------------------------
// Core side of the register and vector bus
// ----------------------------------------
module cpu_core_model (
  input  wire logic        mclk,
  output      logic [15:0] addr,
  output      logic        direct_mode,
  output      logic [7:0]  wdata,
  output      logic        wr,
  output      logic        rd,
  input  wire logic [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    addr = 16'h0000;
    direct_mode = 1'b0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle store; data line flips once the strobe is gone
  task automatic write_byte(input logic [15:0] a, input logic dm, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    direct_mode <= dm;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // One-cycle load; data taken in the following cycle only
  task automatic read_byte(input logic [15:0] a, input logic dm, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    direct_mode <= dm;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  // Address only, for the decode view
  task automatic probe(input logic [15:0] a, input logic dm);
    @(posedge mclk);
    addr <= a;
    direct_mode <= dm;
    @(negedge mclk);
  endtask
endmodule

// File: tb/vector_map_and_stop_gating_test.sv
module vector_map_and_stop_gating_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst, stop_req, wake, rtc_enable, osc_high_range;
  logic        int_ref_clock_enable, int_ref_stop_enable, ext_ref_clock_enable, ext_ref_stop_enable;
  logic [15:0] addr;
  logic        direct_mode, wr, rd;
  logic [7:0]  wdata, rdata, flash_protection_byte, flash_option_byte;
  logic [7:0]  nv_image [16];
  logic [2:0]  region;
  logic [63:0] backdoor_key;
  logic        periph_clk_en, debug_clk_en, cmp_run, adc_run, int_ref_run, rtc_run;
  logic        regulator_full, ext_osc_run, core_power_on, io_hold;
  int          fail_count = 0;
  int          checked = 0;

  vector_map_and_stop_gating uut (.mclk, .rst, .addr, .direct_mode, .wdata, .wr, .rd, .rdata, .region,
    .nv_image, .stop_req, .wake, .int_ref_clock_enable, .int_ref_stop_enable, .ext_ref_clock_enable,
    .ext_ref_stop_enable, .osc_high_range, .rtc_enable, .periph_clk_en, .debug_clk_en, .cmp_run, .adc_run,
    .int_ref_run, .rtc_run, .regulator_full, .ext_osc_run, .core_power_on, .io_hold, .backdoor_key,
    .flash_protection_byte, .flash_option_byte);
  cpu_core_model core (.mclk, .addr, .direct_mode, .wdata, .wr, .rd, .rdata);

  // Clock
  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task report_and_stop;
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_nv(input logic [7:0] s);
    logic [63:0] key;
    for (int k = 0; k < 16; k++) nv_image[k] <= s + 8'h13 * k[7:0];
    rst <= 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int k = 0; k < 8; k++) key[8*k +: 8] = s + 8'h13 * k[7:0];
    chk("prot", 64'(8'(s + 8'hf7)), flash_protection_byte);
    chk("opt", 64'(8'(s + 8'h1d)), flash_option_byte);
    chk("key", key, backdoor_key);
    core.write_byte(16'hffbd, 1'b0, 8'h00);
    core.write_byte(16'hffbf, 1'b0, 8'h00);
    repeat (2) @(posedge mclk);
    chk("prot kept", 64'(8'(s + 8'hf7)), flash_protection_byte);
    chk("opt kept", 64'(8'(s + 8'h1d)), flash_option_byte);
  endtask

  task automatic test_decode;
    logic [15:0] a [12] = '{16'h0000, 16'h007f, 16'h0080, 16'h17ff, 16'h1800, 16'h18ff,
                            16'h1900, 16'hffaf, 16'hffb0, 16'hffbf, 16'hffc0, 16'hffff};
    logic [2:0]  r [12] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h4, 3'h4};
    for (int k = 0; k < 12; k++) begin
      core.probe(a[k], 1'b0);
      chk("region", r[k], region);
    end
    core.probe(16'h187f, 1'b1);
    chk("direct region", 3'h1, region);
  endtask

  task automatic test_vectors;
    logic [7:0] hi, lo;
    for (int s = 0; s < 32; s++) begin
      core.read_byte(16'hffc0 + 16'(2 * s), 1'b0, hi);
      core.read_byte(16'hffc1 + 16'(2 * s), 1'b0, lo);
      chk("vector", 16'h8000 + 16'(4 * s), {hi, lo});
    end
  endtask

  task automatic test_ctrl;
    logic [7:0] d;
    core.write_byte(16'h007f, 1'b0, 8'hff);
    core.read_byte(16'h007f, 1'b0, d);
    chk("ctrl", 8'h17, d & 8'hf7);
    foreach (d[b]) if (b inside {0, 1, 2, 4}) begin
      core.read_byte(16'hab7f, 1'b1, d);
      core.write_byte(16'hcd7f, 1'b1, d & ~(8'h01 << b));
      core.read_byte(16'h007f, 1'b0, d);
      chk("bit clear", 8'h00, d & (8'h01 << b));
    end
    core.read_byte(16'h007f, 1'b0, d);
    chk("ctrl cleared", 8'h00, d & 8'hf7);
    core.read_byte(16'h1880, 1'b0, d);
    chk("high page", 8'h00, d);
  endtask

  task automatic test_stop;
    logic       lt;
    logic [9:0] e;
    for (int i = 0; i < 64; i++) begin
      core.write_byte(16'h007f, 1'b0, {3'h0, i[3], 1'b0, i[2:0]});
      {int_ref_clock_enable, int_ref_stop_enable} <= {i[4], i[5] | i[0]};
      {ext_ref_clock_enable, ext_ref_stop_enable} <= {i[5], i[4] | i[1]};
      {osc_high_range, rtc_enable} <= {i[2] ^ i[4], i[5]};
      stop_req <= 1'b1;
      @(posedge mclk);
      stop_req <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      lt = !(i[3] && !i[0] && !i[1]);
      e = {1'b0, i[1], lt & i[0], lt & i[2] & i[0], lt & int_ref_clock_enable & int_ref_stop_enable,
           rtc_enable, i[0] | i[1], lt & ext_ref_clock_enable & ext_ref_stop_enable & (!osc_high_range | i[0]),
           lt, 1'b1};
      chk("stop", e, {periph_clk_en, debug_clk_en, cmp_run, adc_run, int_ref_run, rtc_run, regulator_full,
                      ext_osc_run, core_power_on, io_hold});
      @(posedge mclk);
      wake <= 1'b1;
      @(posedge mclk);
      wake <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      chk("run", 10'h3fe, {periph_clk_en, debug_clk_en, cmp_run, adc_run, int_ref_run, rtc_run, regulator_full,
                           ext_osc_run, core_power_on, io_hold});
    end
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {stop_req, wake, rtc_enable, osc_high_range} = 4'h0;
    {int_ref_clock_enable, int_ref_stop_enable, ext_ref_clock_enable, ext_ref_stop_enable} = 4'h0;
    for (int k = 0; k < 16; k++) nv_image[k] = 8'hff;
    test_nv(8'h21);
    test_decode();
    test_vectors();
    test_ctrl();
    test_stop();
    test_nv(8'h5a);
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end
endmodule
